//--- src/asa_alarm_top.sv
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/100ps
`include "asa_defs.svh"
// Function
// - Live bit reads the alarm condition as it is now
// - Sticky sets on a live change, holds until software clears it
// - Alarm pin shows live or sticky per alarm type, high when present
// - Aggregated alert built from sticky bits only
// - Offset alarm sets beyond rejection range, clears inside acceptance range
// - Loss-of-signal follows period above threshold
// - Activity alarm follows frequency above threshold
// - Holdover live while the digital PLL is in holdover
// - Locked live only while digital PLL and analog PLL both locked
// - Sticky sets on both rising and falling live edges
// - Only live bits clear by themselves; sticky needs software
// - PLL entering or leaving locked or holdover raises sticky alarms; state readable
// - Each alarm has live, sticky, clear and effect control bits
// - Enabled alarm drives a pin, individual or through alert
// - Any single or combination of sticky bits clearable at once
// - Each reference monitor has block sticky, block clear, controls
// - Each PLL has block sticky, block clear, controls, state field
// - Alert, lock and holdover pins held until alarm sticky and block sticky both cleared
// - Global enable passes or blocks all new alarms
// - One pin can be the alert; per-alarm alert enables
// - Alert is OR of enabled stickies, drops when all are cleared
// - LOS pin follows live; lock and holdover pins follow sticky
module asa_alarm_top (
	// Clock, enable and reset
	input  wire logic                  clk,
	input  wire logic                  arst_n,
	input  wire logic                  ce,
	// Avalon-MM slave
	input  wire logic [7:0]            avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire asa_pkg::asa_word_t    avs_writedata,
	input  wire logic [3:0]            avs_byteenable,
	output asa_pkg::asa_word_t         avs_readdata,
	output logic                       avs_waitrequest,
	// Reference monitor indications
	input  wire logic [3:0]            ref_above_reject,
	input  wire logic [3:0]            ref_within_accept,
	input  wire logic [3:0]            ref_period_over,
	input  wire logic [3:0]            ref_freq_over,
	// Digital PLL states and analog PLL lock
	input  wire asa_pkg::asa_dpll_state_e dpll_state [3],
	input  wire logic                  apll_locked,
	// Status pins
	output logic [3:0]                 pin_out,
	output logic [3:0]                 pin_oe_n
);
	import asa_pkg::*;

	localparam int NA = `ASA_N_ALM;
	localparam int NB = `ASA_N_BLK;
	localparam int NR = `ASA_N_REF;
	localparam int NP = `ASA_N_PLL;
	localparam int NG = `ASA_N_PIN;

	// Block that owns an alarm: monitors first, then PLLs
	function automatic logic [2:0] blk_of(input int idx);
		if (idx < 12)
			return 3'(idx % NR);
		return `ASA_BLK_PLL + 3'((idx - 12) % NP);
	endfunction

	// Byte-enable mask for a write
	function automatic asa_word_t be_mask(input logic [3:0] be);
		asa_word_t m;
		m = 32'h0000_0000;
		for (int b = 0; b < 4; b++)
			m[b*8 +: 8] = {8{be[b]}};
		return m;
	endfunction

	// Register state
	logic              glob_en_reg;
	logic [NA-1:0]     alert_en_reg;
	logic [NA-1:0]     pin_en_reg;
	logic [31:0]       pin_cfg_reg;
	logic [NB-1:0]     blk_sticky_reg;
	logic              wait_reg;
	asa_word_t         rdata_reg;
	logic [NG-1:0]     pin_out_reg;
	logic [NG-1:0]     pin_oe_n_reg;

	// Decoded signals
	logic [NA-1:0]     live;
	logic [NA-1:0]     sticky;
	logic [NA-1:0]     sticky_clr;
	logic [NB-1:0]     blk_clr;
	logic [NB-1:0]     blk_any;
	logic [NA-1:0]     blk_of_alm;
	logic [NR-1:0]     foff_live;
	logic [NP-1:0]     hold_live;
	logic [NP-1:0]     lock_live;
	logic              wr_commit;
	asa_word_t         wmask;
	asa_word_t         wdata_m;
	asa_word_t         rdata_next;
	logic              alert_any;
	logic [NG-1:0]     pin_next;
	logic [NG-1:0]     pin_oe_n_next;

	// Offset alarm hysteresis, one per reference monitor
	for (genvar r = 0; r < NR; r++) begin : g_ref
		asa_freq_hyst u_hyst (
			.clk           (clk),
			.arst_n        (arst_n),
			.ce            (ce),
			.above_reject  (ref_above_reject[r]),
			.within_accept (ref_within_accept[r]),
			.live          (foff_live[r])
		);
	end

	// PLL live conditions from the reported state
	always_comb begin
		for (int p = 0; p < NP; p++) begin
			hold_live[p] = (dpll_state[p] == ASA_PLL_HOLDOVER);
			lock_live[p] = (dpll_state[p] == ASA_PLL_LOCKED) & apll_locked;
		end
	end

	// Live vector in alarm order; offset bits from the hysteresis flops, the rest straight from the sources
	assign live = {lock_live, hold_live, ref_freq_over, ref_period_over, foff_live};

	// One sticky latch per alarm
	for (genvar a = 0; a < NA; a++) begin : g_alm
		asa_sticky_cell u_cell (
			.clk     (clk),
			.arst_n  (arst_n),
			.ce      (ce),
			.live    (live[a]),
			.glob_en (glob_en_reg),
			.clr     (sticky_clr[a]),
			.sticky  (sticky[a])
		);
	end

	// Bus transfer commits on the edge the master sees waitrequest low
	assign wr_commit = avs_write & ~wait_reg;
	assign wmask     = be_mask(avs_byteenable);
	assign wdata_m   = avs_writedata & wmask;

	// Write-one-to-clear pulses for alarm and block stickies
	always_comb begin
		sticky_clr = '0;
		blk_clr    = '0;
		if (wr_commit && avs_address == `ASA_OFS_STICKY)
			sticky_clr = wdata_m[NA-1:0];
		if (wr_commit && avs_address == `ASA_OFS_BLK)
			blk_clr = wdata_m[NB-1:0];
	end

	// Which blocks have an alarm sticky set, and each alarm's block sticky
	always_comb begin
		blk_any = '0;
		blk_of_alm = '0;
		for (int a = 0; a < NA; a++) begin
			blk_any[blk_of(a)] = blk_any[blk_of(a)] | sticky[a];
			blk_of_alm[a] = blk_sticky_reg[blk_of(a)];
		end
	end

	// Block stickies re-set while any owned alarm sticky stays set
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			blk_sticky_reg <= '0;
		else if (ce)
			blk_sticky_reg <= blk_any | (blk_sticky_reg & ~blk_clr);
	end

	// Global alarm enable
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			glob_en_reg <= 1'(`ASA_RST_CTRL);
		else if (ce && wr_commit && avs_address == `ASA_OFS_CTRL && avs_byteenable[0])
			glob_en_reg <= avs_writedata[`ASA_CTRL_GEN_BIT];
	end

	// Per-alarm effect controls
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			alert_en_reg <= NA'(`ASA_RST_ZERO);
			pin_en_reg   <= NA'(`ASA_RST_ZERO);
		end else if (ce && wr_commit) begin
			if (avs_address == `ASA_OFS_ALERT_EN)
				alert_en_reg <= (alert_en_reg & ~wmask[NA-1:0]) | wdata_m[NA-1:0];
			if (avs_address == `ASA_OFS_PIN_EN)
				pin_en_reg <= (pin_en_reg & ~wmask[NA-1:0]) | wdata_m[NA-1:0];
		end
	end

	// Pin mode and selection, one byte per pin
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			pin_cfg_reg <= `ASA_RST_ZERO;
		else if (ce && wr_commit && avs_address == `ASA_OFS_PIN_CFG)
			pin_cfg_reg <= (pin_cfg_reg & ~wmask) | wdata_m;
	end

	// Aggregated alert: enabled alarms, sticky only, with block sticky held
	assign alert_any = |(alert_en_reg & (sticky | blk_of_alm));

	// Per-pin selection of what to show
	always_comb begin
		asa_pin_mode_e mode;
		logic [1:0]    sel;
		int            idx;
		mode = ASA_PIN_OFF;
		sel = 2'h0;
		idx = 0;
		pin_next = '0;
		pin_oe_n_next = '1;
		for (int g = 0; g < NG; g++) begin
			mode = asa_pin_mode_e'(pin_cfg_reg[g*`ASA_PIN_FLD_W + `ASA_PIN_MODE_LSB +: 3]);
			sel  = pin_cfg_reg[g*`ASA_PIN_FLD_W + `ASA_PIN_SEL_LSB +: 2];
			pin_oe_n_next[g] = (mode == ASA_PIN_OFF);
			case (mode)
				ASA_PIN_LOS: begin
					idx = int'(`ASA_ALM_LOS) + int'(sel);
					pin_next[g] = live[idx] & pin_en_reg[idx];
				end
				ASA_PIN_LOL: begin
					idx = int'(`ASA_ALM_LOCK) + int'(sel);
					if (sel < 2'(NP))
						pin_next[g] = (sticky[idx] | blk_of_alm[idx]) & pin_en_reg[idx];
				end
				ASA_PIN_HOLD: begin
					idx = int'(`ASA_ALM_HOLD) + int'(sel);
					if (sel < 2'(NP))
						pin_next[g] = (sticky[idx] | blk_of_alm[idx]) & pin_en_reg[idx];
				end
				ASA_PIN_ALERT: begin
					pin_next[g] = alert_any;
				end
				default: begin
					pin_next[g] = 1'b0;
				end
			endcase
		end
	end

	// Pins come straight from flip-flops; high means alarm present
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_out_reg  <= '0;
			pin_oe_n_reg <= '1;
		end else if (ce) begin
			pin_out_reg  <= pin_next;
			pin_oe_n_reg <= pin_oe_n_next;
		end
	end

	// Read mux; unmapped addresses read as zero
	always_comb begin
		rdata_next = 32'h0000_0000;
		case (avs_address)
			`ASA_OFS_CTRL:     rdata_next[`ASA_CTRL_GEN_BIT] = glob_en_reg;
			`ASA_OFS_LIVE:     rdata_next[NA-1:0] = live;
			`ASA_OFS_STICKY:   rdata_next[NA-1:0] = sticky;
			`ASA_OFS_BLK:      rdata_next[NB-1:0] = blk_sticky_reg;
			`ASA_OFS_ALERT_EN: rdata_next[NA-1:0] = alert_en_reg;
			`ASA_OFS_PIN_EN:   rdata_next[NA-1:0] = pin_en_reg;
			`ASA_OFS_PIN_CFG:  rdata_next = pin_cfg_reg;
			`ASA_OFS_PLL_ST: begin
				for (int p = 0; p < NP; p++)
					rdata_next[p*`ASA_PLL_ST_W +: 3] = dpll_state[p];
			end
			`ASA_OFS_PIN_ST: begin
				rdata_next[NG-1:0] = pin_out_reg;
				rdata_next[8] = alert_any;
			end
			default: rdata_next = 32'h0000_0000;
		endcase
	end

	// Waitrequest drops one cycle after a request, for one cycle only
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			wait_reg <= 1'b1;
		else if (ce) begin
			if (wait_reg && (avs_read || avs_write))
				wait_reg <= 1'b0;
			else
				wait_reg <= 1'b1;
		end
	end

	// Read data captured as waitrequest drops, held until the next read
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			rdata_reg <= 32'h0000_0000;
		else if (ce && wait_reg && avs_read)
			rdata_reg <= rdata_next;
	end

	assign avs_readdata    = rdata_reg;
	assign avs_waitrequest = wait_reg;
	assign pin_out         = pin_out_reg;
	assign pin_oe_n        = pin_oe_n_reg;

endmodule

//--- src/asa_defs.svh
`ifndef ASA_DEFS_SVH
`define ASA_DEFS_SVH

// Block counts, fixed
`define ASA_N_REF        4
`define ASA_N_PLL        3
`define ASA_N_ALM        18
`define ASA_N_BLK        7
`define ASA_N_PIN        4

// Register byte offsets on the Avalon slave
`define ASA_OFS_CTRL     8'h00
`define ASA_OFS_LIVE     8'h04
`define ASA_OFS_STICKY   8'h08
`define ASA_OFS_BLK      8'h0C
`define ASA_OFS_ALERT_EN 8'h10
`define ASA_OFS_PIN_EN   8'h14
`define ASA_OFS_PIN_CFG  8'h18
`define ASA_OFS_PLL_ST   8'h1C
`define ASA_OFS_PIN_ST   8'h20

// Field positions
`define ASA_CTRL_GEN_BIT 0
`define ASA_ALM_FOFF     5'd0
`define ASA_ALM_LOS      5'd4
`define ASA_ALM_ACT      5'd8
`define ASA_ALM_HOLD     5'd12
`define ASA_ALM_LOCK     5'd15
`define ASA_BLK_PLL      3'd4
`define ASA_PIN_FLD_W    8
`define ASA_PIN_MODE_LSB 0
`define ASA_PIN_SEL_LSB  4
`define ASA_PLL_ST_W     4

// Reset values
`define ASA_RST_CTRL     32'h0000_0001
`define ASA_RST_ZERO     32'h0000_0000

`endif

//--- src/asa_pkg.sv
package asa_pkg;

	// Digital PLL state as reported by each loop
	typedef enum logic [2:0] {
		ASA_PLL_FREERUN,
		ASA_PLL_ACQUIRE,
		ASA_PLL_LOCKREC,
		ASA_PLL_LOCKED,
		ASA_PLL_HOLDOVER
	} asa_dpll_state_e;

	// What a status pin shows
	typedef enum logic [2:0] {
		ASA_PIN_OFF,
		ASA_PIN_LOS,
		ASA_PIN_LOL,
		ASA_PIN_HOLD,
		ASA_PIN_ALERT
	} asa_pin_mode_e;

	typedef logic [31:0] asa_word_t;

endpackage

//--- src/asa_freq_hyst.sv
`timescale 1ns/100ps
// Frequency offset live alarm with hysteresis between the two ranges
module asa_freq_hyst (
	// Clock and reset
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic ce,
	// Monitor indications
	input  wire logic above_reject,
	input  wire logic within_accept,
	// Live alarm
	output logic      live
);
	import asa_pkg::*;

	// Set beyond rejection, cleared only once back inside acceptance
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			live <= 1'b0;
		end else if (ce) begin
			if (above_reject)
				live <= 1'b1;
			else if (within_accept)
				live <= 1'b0;
		end
	end

endmodule

//--- src/asa_sticky_cell.sv
`timescale 1ns/100ps
// One alarm's sticky latch, set on either edge of the live condition
module asa_sticky_cell (
	// Clock and reset
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic ce,
	// Live condition and controls
	input  wire logic live,
	input  wire logic glob_en,
	input  wire logic clr,
	// Latched alarm
	output logic      sticky
);
	import asa_pkg::*;

	logic live_prev_reg;
	logic change;

	// Previous value is tracked even when disabled, so old edges are not replayed
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			live_prev_reg <= 1'b0;
		else if (ce)
			live_prev_reg <= live;
	end

	assign change = live ^ live_prev_reg;

	// Set wins over a clear in the same cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			sticky <= 1'b0;
		else if (ce)
			sticky <= (change & glob_en) | (sticky & ~clr);
	end

endmodule

//--- tb/asa_alarm_monitor.sv
`timescale 1ns/100ps
`include "asa_defs.svh"
// Port-level checks of bus handshake and live status
module asa_alarm_monitor (
	// Clock and reset
	input wire logic                     clk,
	input wire logic                     arst_n,
	input wire logic                     ce,
	// Bus
	input wire logic [7:0]               avs_address,
	input wire logic                     avs_read,
	input wire logic                     avs_write,
	input wire asa_pkg::asa_word_t       avs_readdata,
	input wire logic                     avs_waitrequest,
	// Sources and pins
	input wire logic [3:0]               ref_period_over,
	input wire logic [3:0]               ref_freq_over,
	input wire asa_pkg::asa_dpll_state_e dpll_state [3],
	input wire logic                     apll_locked,
	input wire logic [3:0]               pin_out,
	input wire logic [3:0]               pin_oe_n
);
	import asa_pkg::*;
	logic [2:0] hold_c;
	logic [2:0] lock_c;
	logic       rd_go;
	// PLL live view rebuilt from raw inputs
	always_comb begin
		for (int p = 0; p < 3; p++) begin
			hold_c[p] = dpll_state[p] == ASA_PLL_HOLDOVER;
			lock_c[p] = dpll_state[p] == ASA_PLL_LOCKED && apll_locked;
		end
	end
	// Read taken at this edge
	assign rd_go = avs_read && avs_waitrequest && ce;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest && ce
		|=> !avs_waitrequest) else $error("no answer one cycle after request");
	a_wait_idle: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
		else $error("waitrequest low without request");
	a_wait_one: assert property ($fell(avs_waitrequest) |=> $rose(avs_waitrequest))
		else $error("waitrequest low longer than one cycle");
	a_unmapped_zero: assert property (rd_go && avs_address == 8'h24
		|=> avs_readdata == 32'h0) else $error("unmapped read not zero");
	a_live_ref: assert property (rd_go && avs_address == `ASA_OFS_LIVE
		|=> avs_readdata[11:4] == $past({ref_freq_over, ref_period_over}))
		else $error("reference live bits wrong");
	a_live_pll: assert property (rd_go && avs_address == `ASA_OFS_LIVE
		|=> avs_readdata[17:12] == $past({lock_c, hold_c})) else $error("pll live wrong");
	a_pll_state: assert property (rd_go && avs_address == `ASA_OFS_PLL_ST
		|=> avs_readdata[2:0] == $past(dpll_state[0])) else $error("pll state wrong");
	a_reset_pins: assert property ($rose(arst_n) |-> pin_out == 4'h0 && pin_oe_n == 4'hF)
		else $error("pins not idle after reset");
endmodule
bind asa_alarm_top asa_alarm_monitor asa_alarm_monitor_i (.clk, .arst_n, .ce, .avs_address,
	.avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .ref_period_over, .ref_freq_over,
	.dpll_state, .apll_locked, .pin_out, .pin_oe_n);

//--- tb/asa_host_model.sv
`timescale 1ns/100ps
`include "asa_defs.svh"
// Host software polling the alarm block
module asa_host_model (
	// Clock
	input wire logic               clk,
	// Avalon-MM master
	output logic [7:0]             avs_address,
	output logic                   avs_read,
	output logic                   avs_write,
	output asa_pkg::asa_word_t     avs_writedata,
	output logic [3:0]             avs_byteenable,
	input wire asa_pkg::asa_word_t avs_readdata,
	input wire logic               avs_waitrequest
);
	import asa_pkg::*;
	// Bus idle from time zero
	initial begin
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h0;
	end
	// One transfer, held until waitrequest is seen low
	task xfer(input logic w, input logic [7:0] a, input asa_word_t d,
		input logic [3:0] be, output asa_word_t q);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_read <= !w;
		avs_write <= w;
		// No cycle limit here; a hang is left to the bench watchdog
		do begin
			@(posedge clk);
		end while (avs_waitrequest);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	// Service: find causes, then clear alarms before blocks so none re-set
	task service();
		asa_word_t st;
		asa_word_t bk;
		asa_word_t dummy;
		xfer(1'b0, `ASA_OFS_STICKY, 32'h0, 4'hF, st);
		xfer(1'b0, `ASA_OFS_BLK, 32'h0, 4'hF, bk);
		xfer(1'b1, `ASA_OFS_STICKY, st, 4'hF, dummy);
		xfer(1'b1, `ASA_OFS_BLK, bk, 4'hF, dummy);
	endtask
endmodule

//--- tb/asa_alarm_top_tb.sv
`timescale 1ns/100ps
`include "asa_defs.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module asa_alarm_top_tb;
	import asa_pkg::*;
	logic            clk = 1'b0;
	logic            arst_n = 1'b0;
	logic            ce = 1'b1;
	logic [7:0]      avs_address;
	logic            avs_read;
	logic            avs_write;
	asa_word_t       avs_writedata;
	logic [3:0]      avs_byteenable;
	asa_word_t       avs_readdata;
	logic            avs_waitrequest;
	logic [3:0]      ref_above_reject = 4'h0;
	logic [3:0]      ref_within_accept = 4'h0;
	logic [3:0]      ref_period_over = 4'h0;
	logic [3:0]      ref_freq_over = 4'h0;
	asa_dpll_state_e dpll_state [3] = '{default: ASA_PLL_FREERUN};
	logic            apll_locked = 1'b0;
	logic [3:0]      pin_out;
	logic [3:0]      pin_oe_n;
	int              failures = 0;
	int              samples_checked = 0;
	int              seed = 32'h25EC;
	asa_word_t       prev = 32'h0;
	asa_word_t       exp_st = 32'h0;
	asa_word_t       exp_blk = 32'h0;
	asa_word_t       q;
	asa_word_t       m;
	logic [3:0]      foff_m = 4'h0;
	logic            glob = 1'b1;
	// Device under test; clock enable driven by the bench
	asa_alarm_top asa_alarm_top_i (.clk, .arst_n, .ce, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.ref_above_reject, .ref_within_accept, .ref_period_over, .ref_freq_over,
		.dpll_state, .apll_locked, .pin_out, .pin_oe_n);
	asa_host_model asa_host_model_i (.clk, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);
	// 200 MHz clock
	always #2.5 clk = ~clk;
	task conclude();
		if (failures == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Expected live word from the present inputs
	function asa_word_t live_m();
		asa_word_t v;
		v = {14'h0, 6'h0, ref_freq_over, ref_period_over, foff_m};
		for (int p = 0; p < 3; p++) begin
			v[12+p] = dpll_state[p] == ASA_PLL_HOLDOVER;
			v[15+p] = dpll_state[p] == ASA_PLL_LOCKED && apll_locked;
		end
		return v;
	endfunction
	function asa_word_t pll_m();
		asa_word_t v;
		v = 32'h0;
		for (int p = 0; p < 3; p++) v[4*p+:3] = dpll_state[p];
		return v;
	endfunction
	// Let inputs land, then advance the sticky model
	task settle();
		asa_word_t lv;
		repeat (4) @(posedge clk);
		foff_m = (foff_m | ref_above_reject) & ~(ref_within_accept & ~ref_above_reject);
		lv = live_m();
		if (glob) exp_st |= lv ^ prev;
		prev = lv;
		for (int r = 0; r < 4; r++) if (exp_st[r] | exp_st[4+r] | exp_st[8+r]) exp_blk[r] = 1;
		for (int p = 0; p < 3; p++) if (exp_st[12+p] | exp_st[15+p]) exp_blk[4+p] = 1;
	endtask
	task rd(input logic [7:0] a, input asa_word_t e);
		asa_host_model_i.xfer(1'b0, a, 32'h0, 4'hF, q);
		`CHK(q, e)
	endtask
	task wr(input logic [7:0] a, input asa_word_t d, input logic [3:0] be);
		asa_host_model_i.xfer(1'b1, a, d, be, q);
	endtask
	task rnd();
		@(posedge clk);
		ref_above_reject <= 4'($random(seed));
		ref_within_accept <= 4'($random(seed));
		ref_period_over <= 4'($random(seed));
		ref_freq_over <= 4'($random(seed));
		apll_locked <= 1'($random(seed));
		for (int p = 0; p < 3; p++)
			dpll_state[p] <= asa_dpll_state_e'(3'($unsigned($random(seed)) % 5));
		settle();
	endtask
	task chk_pins(input logic [3:0] e);
		repeat (3) @(posedge clk);
		`CHK(pin_out, e)
	endtask
	// Hang guard
	initial begin
		#200000;
		failures++;
		conclude();
	end
	initial begin
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rd(`ASA_OFS_CTRL, `ASA_RST_CTRL);
		rd(`ASA_OFS_ALERT_EN, `ASA_RST_ZERO);
		rd(8'h24, 32'h0);
		// Random alarm traffic against the model
		repeat (10) begin
			rnd();
			rd(`ASA_OFS_LIVE, live_m());
			rd(`ASA_OFS_STICKY, exp_st);
			rd(`ASA_OFS_BLK, exp_blk);
			rd(`ASA_OFS_PLL_ST, pll_m());
		end
		// Lane-masked then random clears leave other bits alone
		wr(`ASA_OFS_STICKY, 32'h3FFFF, 4'h1);
		exp_st &= ~32'hFF;
		rd(`ASA_OFS_STICKY, exp_st);
		m = $random(seed);
		wr(`ASA_OFS_STICKY, m, 4'hF);
		exp_st &= ~m;
		rd(`ASA_OFS_STICKY, exp_st);
		// Global enable off holds back new alarms
		wr(`ASA_OFS_CTRL, 32'h0, 4'hF);
		glob = 1'b0;
		rnd();
		rd(`ASA_OFS_STICKY, exp_st);
		wr(`ASA_OFS_CTRL, 32'h1, 4'hF);
		glob = 1'b1;
		// Quiet sources and clear everything through the host
		@(posedge clk);
		{ref_above_reject, ref_period_over, ref_freq_over, apll_locked} <= 13'h0;
		ref_within_accept <= 4'hF;
		dpll_state <= '{default: ASA_PLL_FREERUN};
		settle();
		asa_host_model_i.service();
		rd(`ASA_OFS_STICKY, 32'h0);
		rd(`ASA_OFS_BLK, 32'h0);
		// Pins: LOS ref1, lock PLL0, holdover PLL2, alert on LOS ref1
		wr(`ASA_OFS_PIN_EN, 32'h3FFFF, 4'hF);
		wr(`ASA_OFS_ALERT_EN, 32'h20, 4'hF);
		wr(`ASA_OFS_PIN_CFG, 32'h0423_0211, 4'hF);
		chk_pins(4'h0);
		`CHK(pin_oe_n, 4'h0)
		// Clock enable low freezes the pins against a live change
		@(posedge clk);
		ce <= 1'b0;
		ref_period_over <= 4'h2;
		chk_pins(4'h0);
		ce <= 1'b1;
		@(posedge clk);
		ref_period_over <= 4'h2;
		apll_locked <= 1'b1;
		dpll_state <= '{ASA_PLL_LOCKED, ASA_PLL_FREERUN, ASA_PLL_HOLDOVER};
		chk_pins(4'hF);
		rd(`ASA_OFS_PIN_ST, 32'h0000_010F);
		ref_period_over <= 4'h0;
		dpll_state[0] <= ASA_PLL_ACQUIRE;
		chk_pins(4'hE);
		wr(`ASA_OFS_STICKY, 32'h3FFFF, 4'hF);
		chk_pins(4'hE);
		wr(`ASA_OFS_BLK, 32'h7F, 4'hF);
		chk_pins(4'h0);
		conclude();
	end
endmodule
